// ===== core/ofc_formatter.sv
`timescale 1ns/1ps
`default_nettype none
`include "ofc_params.svh"

module ofc_formatter
	import ofc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [7:0] reg_sub_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic clk_pix,
	input wire logic dec_hsync,
	input wire logic dec_vsync,
	input wire logic dec_field,
	input wire logic dec_valid,
	input wire logic [7:0] dec_data,
	output logic pixel_clock_out,
	output logic line_sync_out_n,
	output logic field_sync_out_n,
	output logic pixel_valid_out_n,
	output logic [7:0] pixel_data_out
);

	// --------------------------------------------------
	// reset images
	// --------------------------------------------------
	localparam ofc_sys_state_t SYS_RST = '{
		ctrl: `OFC_CTRL_RST,
		sync_ctl: `OFC_SYNC_RST,
		shadow: {`OFC_CTRL_RST, `OFC_SYNC_RST},
		rdata: 8'h00,
		default: '0
	};
	localparam ofc_pix_state_t PIX_RST = '{
		cfg: {`OFC_CTRL_RST, `OFC_SYNC_RST},
		phase: OFC_ST_BLANK,
		data: `OFC_Y_BLANK,
		line_sync_n: 1'b1,
		field_sync_n: 1'b1,
		valid_n: 1'b1,
		default: '0
	};

	ofc_sys_state_t s_reg; // register side state
	ofc_sys_state_t s_next;
	ofc_pix_state_t p_reg; // link side state
	ofc_pix_state_t p_next;
	logic [7:0] buf_rd_data; // line store output
	logic buf_wr_en; // line store write strobe

	// --------------------------------------------------
	// lookup helpers
	// --------------------------------------------------

	// active length per size, out of range falls back to 601
	function automatic logic [11:0] act_len(input logic [2:0] size);
		case (size)
			`OFC_SZ_QVGA: act_len = `OFC_LEN_QVGA;
			`OFC_SZ_VGA: act_len = `OFC_LEN_VGA;
			`OFC_SZ_CIF: act_len = `OFC_LEN_CIF;
			`OFC_SZ_QCIF: act_len = `OFC_LEN_QCIF;
			`OFC_SZ_RQVGA: act_len = `OFC_LEN_RQVGA;
			`OFC_SZ_RCIF: act_len = `OFC_LEN_RCIF;
			default: act_len = `OFC_LEN_601;
		endcase
	endfunction : act_len

	// active start from line start, nominal figures only
	function automatic logic [11:0] act_start(input logic [2:0] size, input logic std625);
		logic [11:0] s525;
		logic [11:0] s625;
		case (size)
			`OFC_SZ_QVGA: begin s525 = `OFC_S525_QVGA; s625 = `OFC_S625_QVGA; end
			`OFC_SZ_VGA: begin s525 = `OFC_S525_VGA; s625 = `OFC_S625_VGA; end
			`OFC_SZ_CIF: begin s525 = `OFC_S525_CIF; s625 = `OFC_S625_CIF; end
			`OFC_SZ_QCIF: begin s525 = `OFC_S525_QCIF; s625 = `OFC_S625_QCIF; end
			`OFC_SZ_RQVGA: begin s525 = `OFC_S525_RQVGA; s625 = `OFC_S625_RQVGA; end
			`OFC_SZ_RCIF: begin s525 = `OFC_S525_RCIF; s625 = `OFC_S625_RCIF; end
			default: begin s525 = `OFC_S525_601; s625 = `OFC_S625_601; end
		endcase
		act_start = std625 ? s625 : s525;
	endfunction : act_start

	// vertical blanking bit for a frame line
	function automatic logic vbit(input logic [9:0] ln, input logic std625, input logic vsel);
		logic [9:0] e1;
		logic [9:0] e2;
		e1 = vsel ? `OFC_V525_NEW_E1 : `OFC_V525_OLD_E1;
		e2 = vsel ? `OFC_V525_NEW_E2 : `OFC_V525_OLD_E2;
		if (std625)
		begin
			vbit = (ln <= `OFC_V625_E1) || (ln >= `OFC_V625_S2 && ln <= `OFC_V625_E2)
				|| (ln >= `OFC_V625_S3);
		end
		else
		begin
			vbit = (ln <= e1) || (ln >= `OFC_L525_F2 && ln <= e2);
		end
	endfunction : vbit

	// timing code status byte with protection bits
	function automatic logic [7:0] trs_xy(input logic f, input logic v, input logic h);
		trs_xy = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
	endfunction : trs_xy

	// --------------------------------------------------
	// register side, clk_sys
	// --------------------------------------------------

	// register writes, readback and config launch
	always_comb
	begin
		s_next = s_reg;
		// ack synchroniser, only the second stage is looked at
		s_next.ack_s1 = p_reg.req_seen;
		s_next.ack_s2 = s_reg.ack_s1;
		if (reg_wr)
		begin
			case (reg_sub_addr)
				`OFC_CTRL_ADDR: s_next.ctrl = reg_wdata;
				`OFC_SYNC_ADDR: s_next.sync_ctl = reg_wdata & `OFC_SYNC_MASK;
				default: s_next.ctrl = s_reg.ctrl; // other addresses ignored
			endcase
		end
		// launch a new snapshot only when the last one was taken,
		// so the shadow is stable whenever the link side reads it
		if (s_reg.ack_s2 == s_reg.req && s_reg.shadow != {s_reg.ctrl, s_reg.sync_ctl})
		begin
			s_next.shadow = {s_reg.ctrl, s_reg.sync_ctl};
			s_next.req = ~s_reg.req;
		end
		// readback, reserved and unmapped read zero
		case (reg_sub_addr)
			`OFC_CTRL_ADDR: s_next.rdata = s_reg.ctrl;
			`OFC_SYNC_ADDR: s_next.rdata = s_reg.sync_ctl;
			default: s_next.rdata = 8'h00;
		endcase
	end

	// register side flops
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			s_reg <= SYS_RST;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign reg_rdata = s_reg.rdata;

	// --------------------------------------------------
	// link side, clk_pix
	// --------------------------------------------------

	logic [2:0] cfg_size; // picture_size_select
	logic [1:0] cfg_if; // interface_style_select
	logic cfg_vsel; // vblank_bit_timing_select
	logic cfg_sync_en; // sync drive enable in stream style
	logic cfg_std625; // line_standard_select
	logic mode656; // stream style active
	logic dbl; // line doubling active
	logic valid_ok; // this field may carry valid
	logic line_start; // an output line begins this tick
	logic full_start; // that line follows a real input line
	logic [11:0] sav_pos; // blank position where SAV begins
	logic [11:0] len; // active length for this size
	logic [7:0] fill; // byte for timing code slots

	assign cfg_size = p_reg.cfg[8+`OFC_SIZE_MSB:8+`OFC_SIZE_LSB];
	assign cfg_if = p_reg.cfg[8+`OFC_IF_MSB:8+`OFC_IF_LSB];
	assign cfg_vsel = p_reg.cfg[8+`OFC_VSEL_BIT];
	assign cfg_sync_en = p_reg.cfg[`OFC_SYNC_EN_BIT];
	assign cfg_std625 = p_reg.cfg[`OFC_STD_BIT];
	assign mode656 = (cfg_if == `OFC_IF_656);
	assign dbl = (cfg_size == `OFC_SZ_CIF) && !cfg_std625;
	assign valid_ok = (cfg_size == `OFC_SZ_VGA) || (cfg_size == `OFC_SZ_601)
		|| !p_reg.field;
	assign len = act_len(cfg_size);
	assign sav_pos = act_start(cfg_size, cfg_std625) - `OFC_TRS_LEN;
	assign buf_wr_en = dec_valid && !dec_hsync && (p_reg.wr_addr != '1);

	// link side next state
	always_comb
	begin
		p_next = p_reg;
		line_start = 1'b0;
		full_start = 1'b0;
		fill = 8'h00;
		// config snapshot handshake, second stage decides
		p_next.req_s1 = s_reg.req;
		p_next.req_s2 = p_reg.req_s1;
		if (p_reg.req_s2 != p_reg.req_seen)
		begin
			p_next.cfg = s_reg.shadow;
			p_next.req_seen = p_reg.req_s2;
		end
		// output clock is clk_pix divided by two
		p_next.clk_out = ~p_reg.clk_out;
		// write side follows decoder samples every edge
		if (dec_hsync)
		begin
			p_next.wr_bank = ~p_reg.wr_bank;
			p_next.wr_addr = '0;
			p_next.hs_pend = 1'b1;
		end
		else if (buf_wr_en)
		begin
			p_next.wr_addr = p_reg.wr_addr + 1'b1;
		end
		if (dec_vsync)
		begin
			p_next.vs_pend = 1'b1;
			p_next.vs_field = dec_field;
		end
		// output engine moves only as the output clock falls
		if (p_reg.clk_out)
		begin
			if (p_reg.line_ticks != '1)
			begin
				p_next.line_ticks = p_reg.line_ticks + 12'h001;
			end
			// line start follows the detected input sync
			if (p_reg.hs_pend)
			begin
				p_next.hs_pend = dec_hsync;
				p_next.half_len = p_reg.line_ticks >> 1;
				p_next.line_ticks = 12'h000;
				p_next.half_done = 1'b0;
				line_start = 1'b1;
				full_start = 1'b1;
			end
			else if (dbl && !p_reg.half_done && p_reg.line_ticks == p_reg.half_len)
			begin
				p_next.half_done = 1'b1;
				line_start = 1'b1;
			end
			// frame numbering restarts at each field sync
			if (p_reg.vs_pend)
			begin
				p_next.vs_pend = dec_vsync;
				p_next.field = p_reg.vs_field;
				p_next.line_num = !p_reg.vs_field ? 10'h001
					: (cfg_std625 ? `OFC_L625_F2 : `OFC_L525_F2);
				p_next.vs_cnt = 10'h000;
			end
			else if (full_start)
			begin
				p_next.line_num = p_reg.line_num + 10'h001;
			end
			// field sync width counts output lines, so it doubles too
			if (!p_reg.vs_pend && line_start && p_reg.vs_cnt != `OFC_VS_LINES)
			begin
				p_next.vs_cnt = p_reg.vs_cnt + 10'h001;
			end
			// line engine
			if (line_start)
			begin
				p_next.pos = 12'h000;
				p_next.cnt = 12'h000;
				p_next.phase = OFC_ST_BLANK;
				p_next.line_done = 1'b0;
				p_next.trs_v = vbit(p_next.line_num, cfg_std625, cfg_vsel);
				if (full_start)
				begin
					p_next.rd_bank = ~p_reg.wr_bank; // last finished line
				end
			end
			else
			begin
				if (p_reg.pos != '1)
				begin
					p_next.pos = p_reg.pos + 12'h001;
				end
				case (p_reg.phase)
					OFC_ST_BLANK:
					begin
						// SAV placed ahead of active data
						if (!p_reg.line_done && p_next.pos == sav_pos)
						begin
							p_next.phase = OFC_ST_SAV;
							p_next.cnt = 12'h000;
						end
					end
					OFC_ST_SAV:
					begin
						p_next.cnt = p_reg.cnt + 12'h001;
						if (p_reg.cnt == `OFC_TRS_LEN - 12'h001)
						begin
							p_next.phase = OFC_ST_ACTIVE;
							p_next.cnt = 12'h000;
						end
					end
					OFC_ST_ACTIVE:
					begin
						p_next.cnt = p_reg.cnt + 12'h001;
						if (p_reg.cnt == len - 12'h001)
						begin
							p_next.phase = OFC_ST_EAV;
							p_next.cnt = 12'h000;
						end
					end
					OFC_ST_EAV:
					begin
						p_next.cnt = p_reg.cnt + 12'h001;
						if (p_reg.cnt == `OFC_TRS_LEN - 12'h001)
						begin
							p_next.phase = OFC_ST_BLANK;
							p_next.line_done = 1'b1;
						end
					end
					default: p_next.phase = OFC_ST_BLANK;
				endcase
			end
			// read address runs one tick ahead of the byte shown
			if (p_next.phase == OFC_ST_SAV)
			begin
				p_next.rd_addr = '0;
			end
			else if (p_next.phase == OFC_ST_ACTIVE)
			begin
				p_next.rd_addr = p_reg.rd_addr + 1'b1;
			end
			// timing code slots: real codes only in stream style
			case (p_next.cnt[1:0])
				2'h0: fill = mode656 ? `OFC_TRS_ONE : `OFC_Y_BLANK;
				2'h1: fill = mode656 ? `OFC_TRS_ZERO : `OFC_C_BLANK;
				2'h2: fill = mode656 ? `OFC_TRS_ZERO : `OFC_Y_BLANK;
				default: fill = mode656
					? trs_xy(p_reg.field, p_next.trs_v, p_next.phase == OFC_ST_EAV)
					: `OFC_C_BLANK;
			endcase
			// data byte
			case (p_next.phase)
				OFC_ST_ACTIVE: p_next.data = buf_rd_data;
				OFC_ST_SAV, OFC_ST_EAV: p_next.data = fill;
				default: p_next.data = p_next.pos[0] ? `OFC_Y_BLANK : `OFC_C_BLANK;
			endcase
			// strobes, held low in stream style; valid always, syncs unless enabled
			if (mode656)
			begin
				p_next.valid_n = 1'b0;
				p_next.line_sync_n = cfg_sync_en
					? !(p_next.pos < `OFC_HS_WIDTH) : 1'b0;
				p_next.field_sync_n = cfg_sync_en
					? !(p_next.vs_cnt < `OFC_VS_LINES) : 1'b0;
			end
			else
			begin
				p_next.valid_n = !(p_next.phase == OFC_ST_ACTIVE && valid_ok);
				p_next.line_sync_n = !(p_next.pos < `OFC_HS_WIDTH);
				p_next.field_sync_n = !(p_next.vs_cnt < `OFC_VS_LINES);
			end
		end
	end

	// link side flops
	always_ff @(posedge clk_pix or negedge nrst)
	begin
		if (!nrst)
		begin
			p_reg <= PIX_RST;
		end
		else
		begin
			p_reg <= p_next;
		end
	end

	// --------------------------------------------------
	// line store
	// --------------------------------------------------

	// two banks: one fills while the other is read, once or twice
	ofc_line_buf #(
		.DATA_W(8),
		.ADDR_W(`OFC_LINE_AW + 1)
	) u_line_buf (
		.clk_pix(clk_pix),
		.wr_en(buf_wr_en),
		.wr_addr({p_reg.wr_bank, p_reg.wr_addr}),
		.wr_data(dec_data),
		.rd_addr({p_reg.rd_bank, p_reg.rd_addr}),
		.rd_data(buf_rd_data)
	);

	// --------------------------------------------------
	// pins, all from flops
	// --------------------------------------------------
	assign pixel_clock_out = p_reg.clk_out;
	assign line_sync_out_n = p_reg.line_sync_n;
	assign field_sync_out_n = p_reg.field_sync_n;
	assign pixel_valid_out_n = p_reg.valid_n;
	assign pixel_data_out = p_reg.data;

endmodule : ofc_formatter

`default_nettype wire

// ===== core/ofc_params.svh
// Functional notes
// - valid strobe one field only, except VGA/601
// - 525-line CIF emits two lines per input
// - doubled lines also double sync rates
// - stream lengths follow input, not locked
// - active data placed after sync, SAV marks
// - stream style holds syncs and valid low
// - software may enable syncs in stream style
// - two-bit select names four styles, only stream style differs
// - select bit moves 525 vertical blanking bit line
// - rotated QVGA valid for 480 output clocks
// - rotated QVGA 625 strobe mode by codes
// - 525 blanking lines 1-9/264-272 or 1-19/264-282
// - non-stream styles send 10 80 10 80 fillers
`ifndef OFC_PARAMS_SVH
`define OFC_PARAMS_SVH

// --------------------------------------------------
// register map
// --------------------------------------------------
`define OFC_CTRL_ADDR 8'h01
`define OFC_SYNC_ADDR 8'h03
`define OFC_CTRL_RST 8'h00
`define OFC_SYNC_RST 8'h00
`define OFC_SYNC_MASK 8'h03
`define OFC_SIZE_LSB 0
`define OFC_SIZE_MSB 2
`define OFC_IF_LSB 4
`define OFC_IF_MSB 5
`define OFC_VSEL_BIT 6
`define OFC_SYNC_EN_BIT 0
`define OFC_STD_BIT 1

// --------------------------------------------------
// size and style codes
// --------------------------------------------------
`define OFC_SZ_QVGA 3'h0
`define OFC_SZ_VGA 3'h1
`define OFC_SZ_CIF 3'h2
`define OFC_SZ_QCIF 3'h3
`define OFC_SZ_RQVGA 3'h4
`define OFC_SZ_RCIF 3'h5
`define OFC_SZ_601 3'h6
`define OFC_IF_CAM 2'h0
`define OFC_IF_CAM_TRS 2'h1
`define OFC_IF_STROBE 2'h2
`define OFC_IF_656 2'h3

// --------------------------------------------------
// line timing in output clocks
// --------------------------------------------------
`define OFC_LEN_QVGA 12'h280
`define OFC_LEN_VGA 12'h500
`define OFC_LEN_CIF 12'h2C0
`define OFC_LEN_QCIF 12'h160
`define OFC_LEN_RQVGA 12'h1E0
`define OFC_LEN_RCIF 12'h240
`define OFC_LEN_601 12'h5A0
`define OFC_S525_QVGA 12'h076
`define OFC_S525_VGA 12'h0EC
`define OFC_S525_CIF 12'h082
`define OFC_S525_QCIF 12'h041
`define OFC_S525_RQVGA 12'h0C6
`define OFC_S525_RCIF 12'h096
`define OFC_S525_601 12'h0F4
`define OFC_S625_QVGA 12'h07F
`define OFC_S625_VGA 12'h0FE
`define OFC_S625_CIF 12'h08C
`define OFC_S625_QCIF 12'h046
`define OFC_S625_RQVGA 12'h0CF
`define OFC_S625_RCIF 12'h09F
`define OFC_S625_601 12'h108
`define OFC_TRS_LEN 12'h004
`define OFC_HS_WIDTH 12'h020
`define OFC_VS_LINES 10'h003
`define OFC_LINE_AW 11

// --------------------------------------------------
// frame line numbers
// --------------------------------------------------
`define OFC_L525_F2 10'h108
`define OFC_L625_F2 10'h139
`define OFC_V525_OLD_E1 10'h009
`define OFC_V525_OLD_E2 10'h110
`define OFC_V525_NEW_E1 10'h013
`define OFC_V525_NEW_E2 10'h11A
`define OFC_V625_E1 10'h016
`define OFC_V625_S2 10'h137
`define OFC_V625_E2 10'h14F
`define OFC_V625_S3 10'h270

// --------------------------------------------------
// data codes
// --------------------------------------------------
`define OFC_Y_BLANK 8'h10
`define OFC_C_BLANK 8'h80
`define OFC_TRS_ONE 8'hFF
`define OFC_TRS_ZERO 8'h00

`endif

// ===== core/ofc_pkg.sv
`include "ofc_params.svh"

package ofc_pkg;

	// position within one output line
	typedef enum logic [1:0] {OFC_ST_BLANK, OFC_ST_SAV, OFC_ST_ACTIVE, OFC_ST_EAV} ofc_phase_t;

	// register side state, clk_sys domain
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] sync_ctl;
		logic [15:0] shadow;
		logic req;
		logic ack_s1;
		logic ack_s2;
		logic [7:0] rdata;
	} ofc_sys_state_t;

	// link side state, clk_pix domain
	typedef struct packed {
		logic req_s1;
		logic req_s2;
		logic req_seen;
		logic [15:0] cfg;
		logic clk_out;
		logic wr_bank;
		logic [`OFC_LINE_AW-1:0] wr_addr;
		logic rd_bank;
		logic [`OFC_LINE_AW-1:0] rd_addr;
		logic hs_pend;
		logic vs_pend;
		logic vs_field;
		logic [11:0] line_ticks;
		logic [11:0] half_len;
		logic half_done;
		logic line_done;
		ofc_phase_t phase;
		logic [11:0] pos;
		logic [11:0] cnt;
		logic field;
		logic trs_v;
		logic [9:0] line_num;
		logic [9:0] vs_cnt;
		logic [7:0] data;
		logic line_sync_n;
		logic field_sync_n;
		logic valid_n;
	} ofc_pix_state_t;

endpackage : ofc_pkg

// ===== core/ofc_line_buf.sv
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------
// two-bank line store, registered read
// --------------------------------------------------
module ofc_line_buf
	import ofc_pkg::*;
#(
	parameter int DATA_W = 8,
	parameter int ADDR_W = 12
)
(
	input wire logic clk_pix,
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [DATA_W-1:0] rd_data
);

	// storage, no reset: contents only read after a full line
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	// read register, one edge of latency
	logic [DATA_W-1:0] rd_data_reg;

	// write and read on the same edge
	always_ff @(posedge clk_pix)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
		rd_data_reg <= mem[rd_addr];
	end

	assign rd_data = rd_data_reg;

endmodule : ofc_line_buf

`default_nettype wire

// ===== verif/ofc_formatter_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "ofc_params.svh"

module ofc_formatter_checker
	import ofc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [7:0] reg_sub_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic clk_pix,
	input wire logic dec_hsync,
	input wire logic dec_vsync,
	input wire logic dec_field,
	input wire logic dec_valid,
	input wire logic [7:0] dec_data,
	input wire logic pixel_clock_out,
	input wire logic line_sync_out_n,
	input wire logic field_sync_out_n,
	input wire logic pixel_valid_out_n,
	input wire logic [7:0] pixel_data_out
);
	// --------------------------------------------------
	// configuration mirrors
	// --------------------------------------------------
	logic [7:0] ctrl_reg; // format control copy
	logic [1:0] sync_reg; // sync control copy
	logic [9:0] cfg_reg; // copy as seen on the link side
	logic [4:0] age_reg; // link cycles since last change
	logic [11:0] vcnt_reg; // link cycles with valid low
	logic [11:0] len; // active bytes for the size
	logic quiet; // config old enough to be in force
	logic trs; // stream style selected

	// writes as the design takes them
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
		begin
			ctrl_reg <= 8'h00;
			sync_reg <= 2'h0;
		end
		else if (reg_wr && reg_sub_addr == `OFC_CTRL_ADDR)
			ctrl_reg <= reg_wdata;
		else if (reg_wr && reg_sub_addr == `OFC_SYNC_ADDR)
			sync_reg <= reg_wdata[1:0];

	// loose crossing: only used once settled, so no need to synchronise
	always_ff @(posedge clk_pix or negedge nrst)
		if (!nrst)
		begin
			cfg_reg <= 10'h000;
			age_reg <= 5'h00;
			vcnt_reg <= 12'h000;
		end
		else
		begin
			cfg_reg <= {sync_reg, ctrl_reg};
			age_reg <= (cfg_reg != {sync_reg, ctrl_reg}) ? 5'h00 : age_reg + {4'h0, ~&age_reg};
			vcnt_reg <= pixel_valid_out_n ? 12'h000 : vcnt_reg + 12'h001;
		end

	// active length per size code
	always_comb
	begin
		case (cfg_reg[2:0])
			`OFC_SZ_QVGA: len = `OFC_LEN_QVGA;
			`OFC_SZ_VGA: len = `OFC_LEN_VGA;
			`OFC_SZ_CIF: len = `OFC_LEN_CIF;
			`OFC_SZ_QCIF: len = `OFC_LEN_QCIF;
			`OFC_SZ_RQVGA: len = `OFC_LEN_RQVGA;
			`OFC_SZ_RCIF: len = `OFC_LEN_RCIF;
			default: len = `OFC_LEN_601;
		endcase
	end
	assign quiet = &age_reg;
	assign trs = cfg_reg[5:4] == `OFC_IF_656;

	// --------------------------------------------------
	// properties
	// --------------------------------------------------
	AST_DATA_ON_TICK: assert property (@(posedge clk_pix) disable iff (!nrst)
		!$stable(pixel_data_out) |-> $fell(pixel_clock_out)) else $error("data moved off tick");
	AST_STROBE_ON_TICK: assert property (@(posedge clk_pix) disable iff (!nrst)
		!$stable({line_sync_out_n, field_sync_out_n, pixel_valid_out_n}) |->
		$fell(pixel_clock_out)) else $error("strobe moved off tick");
	AST_CLOCK_HALF: assert property (@(posedge clk_pix) disable iff (!nrst)
		pixel_clock_out |=> !pixel_clock_out ##1 pixel_clock_out) else $error("clock not half");
	AST_STREAM_SYNC_LOW: assert property (@(posedge clk_pix) disable iff (!nrst)
		quiet && trs && !cfg_reg[8] |-> !line_sync_out_n && !field_sync_out_n)
		else $error("stream syncs not low");
	AST_STREAM_VALID_LOW: assert property (@(posedge clk_pix) disable iff (!nrst)
		quiet && trs |-> !pixel_valid_out_n) else $error("stream valid not low");
	AST_FILL_BEFORE: assert property (@(posedge clk_pix) disable iff (!nrst)
		$fell(pixel_valid_out_n) && quiet && !trs |-> $past(pixel_data_out, 2) == `OFC_C_BLANK
		&& $past(pixel_data_out, 4) == `OFC_Y_BLANK && $past(pixel_data_out, 6) == `OFC_C_BLANK
		&& $past(pixel_data_out, 8) == `OFC_Y_BLANK) else $error("bad filler before data");
	AST_FILL_AFTER: assert property (@(posedge clk_pix) disable iff (!nrst)
		$rose(pixel_valid_out_n) && quiet && !trs |-> pixel_data_out == `OFC_Y_BLANK ##2
		pixel_data_out == `OFC_C_BLANK ##2 pixel_data_out == `OFC_Y_BLANK ##2
		pixel_data_out == `OFC_C_BLANK) else $error("bad filler after data");
	AST_VALID_SPAN: assert property (@(posedge clk_pix) disable iff (!nrst)
		$rose(pixel_valid_out_n) && quiet |-> vcnt_reg == {len[10:0], 1'b0})
		else $error("valid span wrong");
	AST_CTRL_READ: assert property (@(posedge clk_sys) disable iff (!nrst)
		$past(reg_sub_addr) == `OFC_CTRL_ADDR |-> reg_rdata == $past(ctrl_reg))
		else $error("control read wrong");
	AST_SYNC_READ: assert property (@(posedge clk_sys) disable iff (!nrst)
		$past(reg_sub_addr) == `OFC_SYNC_ADDR |-> reg_rdata == {6'h00, $past(sync_reg)})
		else $error("sync control read wrong");
endmodule : ofc_formatter_checker

bind ofc_formatter ofc_formatter_checker chk (.clk_sys, .nrst, .reg_sub_addr, .reg_wr,
	.reg_wdata, .reg_rdata, .clk_pix, .dec_hsync, .dec_vsync, .dec_field, .dec_valid,
	.dec_data, .pixel_clock_out, .line_sync_out_n, .field_sync_out_n, .pixel_valid_out_n,
	.pixel_data_out);
`default_nettype wire

// ===== verif/ofc_host_receiver.sv
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------
// camera port of the host
// --------------------------------------------------
module ofc_host_receiver
	import ofc_pkg::*;
(
	input wire logic pixel_clock_out,
	input wire logic line_sync_out_n,
	input wire logic pixel_valid_out_n,
	input wire logic [7:0] pixel_data_out,
	output logic cap_tgl,
	output logic [7:0] cap_data,
	output logic [15:0] line_cnt
);
	initial
	begin
		cap_tgl = 1'b0;
		line_cnt = 16'h0000;
	end

	// rising edge, opposite to launch; only valid matters, not its offset
	always @(posedge pixel_clock_out)
		if (pixel_valid_out_n === 1'b0)
		begin
			cap_data <= pixel_data_out;
			cap_tgl <= ~cap_tgl;
		end

	// every line start seen
	always @(negedge line_sync_out_n)
		line_cnt <= line_cnt + 16'h0001;
endmodule : ofc_host_receiver
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ofc_params.svh"

module testbench
	import ofc_pkg::*;
;
	// --------------------------------------------------
	// signals and bookkeeping
	// --------------------------------------------------
	logic clk_sys = 1'b0, clk_pix, nrst, reg_wr, cap_tgl; // clocks, strobes
	logic [7:0] reg_sub_addr, reg_wdata, reg_rdata, dec_data, pixel_data_out, cap_data;
	logic dec_hsync, dec_vsync, dec_field, dec_valid; // decoder side
	logic pixel_clock_out, line_sync_out_n, field_sync_out_n, pixel_valid_out_n;
	logic [15:0] line_cnt, lc0; // line starts seen
	logic [7:0] exp_q[$]; // bytes still owed
	int errors = 0, comparisons = 0, n_cap = 0, i;
	bit armed = 1'b0; // compare captures only when set
	integer seed = 32'h5D4B;

	ofc_formatter dut (.clk_sys, .nrst, .reg_sub_addr, .reg_wr, .reg_wdata, .reg_rdata,
		.clk_pix, .dec_hsync, .dec_vsync, .dec_field, .dec_valid, .dec_data,
		.pixel_clock_out, .line_sync_out_n, .field_sync_out_n, .pixel_valid_out_n,
		.pixel_data_out);
	ofc_host_receiver recv (.pixel_clock_out, .line_sync_out_n, .pixel_valid_out_n,
		.pixel_data_out, .cap_tgl, .cap_data, .line_cnt);

	// clocks; link offset so edges never coincide
	always #2.5 clk_sys = ~clk_sys;
	initial
	begin
		clk_pix = 1'b0;
		#0.7;
		forever #62.5 clk_pix = ~clk_pix;
	end

	// --------------------------------------------------
	// tasks
	// --------------------------------------------------
	task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e)
		begin
			errors++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask : check

	task automatic end_of_test;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_sub_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
	endtask : reg_write

	task automatic reg_check(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk_sys);
		reg_sub_addr = a;
		@(negedge clk_sys);
		check("register", {8'h00, e}, {8'h00, reg_rdata});
	endtask : reg_check

	task automatic vsync(input logic f);
		repeat (4) @(negedge clk_pix);
		dec_vsync = 1'b1;
		dec_field = f;
		@(negedge clk_pix);
		dec_vsync = 1'b0;
	endtask : vsync

	// one input line: start pulse, n bytes, idle to span
	task automatic send_line(input int n, input bit push, input int span);
		logic [7:0] b;
		@(negedge clk_pix);
		dec_hsync = 1'b1;
		@(negedge clk_pix);
		dec_hsync = 1'b0;
		for (int k = 0; k < n; k++)
		begin
			b = $random(seed);
			dec_valid = 1'b1;
			dec_data = b;
			if (push)
				exp_q.push_back(b);
			@(negedge clk_pix);
		end
		dec_valid = 1'b0;
		repeat (span - n) @(negedge clk_pix);
	endtask : send_line

	// --------------------------------------------------
	// watcher and watchdog
	// --------------------------------------------------
	initial
		forever
		begin
			@(cap_tgl);
			n_cap++;
			if (armed && exp_q.size() > 0)
				check("pixel byte", {8'h00, exp_q.pop_front()}, {8'h00, cap_data});
		end

	// about 3600 link cycles expected
	initial
	begin
		repeat (6000) @(posedge clk_pix);
		errors++;
		end_of_test();
	end

	// --------------------------------------------------
	// main sequence
	// --------------------------------------------------
	initial
	begin
		{nrst, reg_wr, reg_sub_addr, reg_wdata} = 18'h00000;
		{dec_hsync, dec_vsync, dec_field, dec_valid, dec_data} = 12'h000;
		repeat (8) @(negedge clk_pix);
		nrst = 1'b1;
		reg_check(`OFC_CTRL_ADDR, `OFC_CTRL_RST);
		reg_check(`OFC_SYNC_ADDR, `OFC_SYNC_RST);
		reg_check(8'h02, 8'h00);
		reg_write(`OFC_SYNC_ADDR, 8'hFF);
		reg_check(`OFC_SYNC_ADDR, 8'h03);
		for (i = 0; i < 4; i++)
		begin
			reg_write(`OFC_CTRL_ADDR, {2'h0, i[1:0], 4'h4});
			reg_check(`OFC_CTRL_ADDR, {2'h0, i[1:0], 4'h4});
		end
		lc0 = $random(seed);
		reg_write(`OFC_CTRL_ADDR, lc0[7:0]);
		reg_check(`OFC_CTRL_ADDR, lc0[7:0]);
		reg_write(8'h07, 8'hA5);
		reg_check(8'h07, 8'h00);
		// small size in strobe style, 525 lines
		reg_write(`OFC_SYNC_ADDR, 8'h00);
		reg_write(`OFC_CTRL_ADDR, {2'h0, `OFC_IF_STROBE, 1'b0, `OFC_SZ_QCIF});
		vsync(1'b1);
		send_line(0, 0, 20);
		check("field sync", 16'h0000, {15'h0, field_sync_out_n});
		n_cap = 0;
		send_line(0, 0, 860);
		check("field one bytes", 16'h0000, n_cap[15:0]);
		vsync(1'b0);
		send_line(352, 1, 860);
		n_cap = 0;
		armed = 1'b1;
		send_line(0, 0, 860);
		armed = 1'b0;
		check("line bytes", 16'h0160, n_cap[15:0]);
		check("bytes left", 16'h0000, 16'(exp_q.size()));
		// short lines keep valid out of the doubled lines
		reg_write(`OFC_CTRL_ADDR, {2'h0, `OFC_IF_STROBE, 1'b0, `OFC_SZ_CIF});
		repeat (2) send_line(0, 0, 250);
		check("field sync end", 16'h0001, {15'h0, field_sync_out_n});
		lc0 = line_cnt;
		send_line(0, 0, 250);
		check("lines per input line", 16'h0002, line_cnt - lc0);
		// stream style, then with syncs enabled
		reg_write(`OFC_CTRL_ADDR, {2'h0, `OFC_IF_656, 1'b0, `OFC_SZ_601});
		send_line(0, 0, 40);
		check("stream strobes", 16'h0000,
			{13'h0, line_sync_out_n, field_sync_out_n, pixel_valid_out_n});
		reg_write(`OFC_SYNC_ADDR, 8'h01);
		// long enough for the sync to rise again before the counted line
		send_line(0, 0, 100);
		lc0 = line_cnt;
		send_line(0, 0, 100);
		check("stream line syncs", 16'h0001, line_cnt - lc0);
		check("stream valid", 16'h0000, {15'h0, pixel_valid_out_n});
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
